// [hdl/lftc_pkg.sv]
// Purpose: shared constants and types of the lan frame type classifier
// Assumes: byte stream on one 25 MHz clock
// Notes: byte indices count from the first byte of the frame
package lftc_pkg;
   // ethernet header layout
   localparam logic [12:0] LFTC_ETH_TL_HI = 13'h000C; // type/length msb
   localparam logic [12:0] LFTC_ETH_LLC = 13'h000E;   // llc start
   // ring header: frame control, two addresses, then llc
   localparam logic [12:0] LFTC_RING_LLC = 13'h000D;
   // llc field offsets relative to llc start
   localparam logic [12:0] LFTC_OFF_DSAP = 13'h0000;
   localparam logic [12:0] LFTC_OFF_SSAP = 13'h0001;
   localparam logic [12:0] LFTC_OFF_CTL = 13'h0002;
   localparam logic [12:0] LFTC_OFF_CTL2 = 13'h0003;
   localparam logic [12:0] LFTC_OFF_OUI = 13'h0003;
   localparam logic [12:0] LFTC_OFF_EXT = 13'h0006;
   localparam logic [12:0] LFTC_OFF_END = 13'h0008;
   // length limits in bytes, address (frame control on ring) through fcs
   localparam logic [12:0] LFTC_ETH_MIN = 13'h0040;  // 64
   localparam logic [12:0] LFTC_ETH_MAX = 13'h05EE;  // 1518
   localparam logic [12:0] LFTC_RING_MAX = 13'h1194; // 4500
   localparam logic [12:0] LFTC_RING_MIN = 13'h0014; // 20, header+llc+fcs
   localparam logic [12:0] LFTC_CNT_SAT = 13'h1FFF;
   localparam logic [15:0] LFTC_TL_MAX = 16'h05DC;   // 1500
   localparam logic [15:0] LFTC_PAD_MIN = 16'h002E;  // 46 payload bytes
   localparam logic [12:0] LFTC_ETH_OVH = 13'h0012;  // 18 header+fcs
   localparam logic [12:0] LFTC_FCS_LEN = 13'h0004;
   // llc code points
   localparam logic [7:0] LFTC_SAP_SNAP = 8'hAA;
   localparam logic [15:0] LFTC_RAW_MARK = 16'hFFFF;
   localparam logic [7:0] LFTC_SNAP_CTL = 8'h03;
   localparam logic [23:0] LFTC_OUI_ENCAP = 24'h000000;
   localparam logic [1:0] LFTC_CTL_UNNUM = 2'h3;
   // crc32, reflected form
   localparam logic [31:0] LFTC_CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] LFTC_CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] LFTC_CRC_RESID = 32'hDEBB20E3;

   typedef enum logic [3:0] {
      LFTC_CL_NONE,
      LFTC_CL_TYPE_FIELD_FRAMING,
      LFTC_CL_RAW_LENGTH_FRAMING,
      LFTC_CL_LENGTH_FRAMING_WITH_LLC,
      LFTC_CL_LENGTH_FRAMING_WITH_SNAP,
      LFTC_CL_LENGTH_SNAP_ENCAP_TYPE,
      LFTC_CL_RING_FRAMING_WITH_LLC,
      LFTC_CL_RING_FRAMING_WITH_SNAP,
      LFTC_CL_RING_SNAP_ENCAP_TYPE
   } lftc_class_e;
endpackage : lftc_pkg

// [hdl/lftc_len_if.sv]
// Purpose: carrier between the parser and the byte counter
// Assumes: single clock domain
// Notes: count holds the bytes taken so far in the current frame
`timescale 1ns/1ps
`default_nettype none
interface lftc_len_if;
   logic byte_stb;
   logic first;
   logic ring;
   logic [12:0] count;
   logic too_long;
   logic too_short;
   modport counter (input byte_stb, first, ring,
                    output count, too_long, too_short);
   modport parser (output byte_stb, first, ring,
                   input count, too_long, too_short);
endinterface : lftc_len_if
`default_nettype wire

// [hdl/lftc_len_count.sv]
// Purpose: frame byte counter and medium length limit check
// Assumes: first is high with the strobe of a frame's first byte
// Notes: count saturates so giant frames still read as too long
`timescale 1ns/1ps
`default_nettype none
module lftc_len_count
   import lftc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   lftc_len_if.counter lk
);
   typedef struct packed {
      logic [12:0] count;
      logic ring;
   } lftc_cnt_s;
   lftc_cnt_s st_reg;
   lftc_cnt_s st_next;

   // count bytes; a new first byte restarts the frame
   always_comb
   begin
      st_next = st_reg;
      if (lk.byte_stb && lk.first)
      begin
         st_next.count = 13'h0001;
         st_next.ring = lk.ring;
      end
      else if (lk.byte_stb && st_reg.count != LFTC_CNT_SAT)
      begin
         st_next.count = st_reg.count + 13'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign lk.count = st_reg.count;
   // limits per medium, counted address (frame control on ring) through fcs
   assign lk.too_long = st_reg.ring ? (st_reg.count > LFTC_RING_MAX)
                                    : (st_reg.count > LFTC_ETH_MAX);
   assign lk.too_short = st_reg.ring ? (st_reg.count < LFTC_RING_MIN)
                                     : (st_reg.count < LFTC_ETH_MIN);
endmodule : lftc_len_count
`default_nettype wire

// [hdl/lftc_classifier.sv]
// Purpose: receive side parser that names the framing of each frame
// Assumes: bytes come from mac logic on clk, one per in_valid cycle
// Notes: result is a one-cycle pulse two cycles after the last byte, none if a first byte comes in the very next cycle
// Function
// - length/type field above 1500 means type framing
// - field at most 1500 means 802.3 length
// - ethernet frames between 64 and 1518 bytes
// - short frames carry pad before the fcs
// - ring frames up to 4500 bytes allowed
// - ring user frames always carry llc header
// - llc has dsap, ssap, one/two-byte control
// - FFFF after length field means raw framing
// - both saps AA means snap, control 3
// - snap carries three-byte oui, two-byte extension
// - oui zero means extension is ether type
// - addresses plus trailing 32-bit crc fcs
// - parse headers in order, each steering next
`timescale 1ns/1ps
`default_nettype none
module lftc_classifier
   import lftc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_first,
   input wire logic in_last,
   input wire logic in_ring,
   output logic res_valid,
   output lftc_class_e res_class,
   output logic [15:0] res_proto,
   output logic [7:0] res_dsap,
   output logic [7:0] res_ssap,
   output logic [15:0] res_ctrl,
   output logic res_ctrl_wide,
   output logic [23:0] res_oui,
   output logic res_len_err,
   output logic res_pad_err,
   output logic res_crc_err,
   output logic res_hdr_err,
   output logic res_discard
);
   typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} lftc_state_e;

   typedef struct packed {
      lftc_state_e state;
      logic ring;
      logic [15:0] tl;
      logic [7:0] dsap;
      logic [7:0] ssap;
      logic [15:0] ctrl;
      logic ctrl_wide;
      logic [23:0] oui;
      logic [15:0] ext;
      logic [31:0] crc;
      logic valid;
      lftc_class_e cls;
      logic [15:0] proto;
      logic len_err;
      logic pad_err;
      logic crc_err;
      logic hdr_err;
      // verdict copies of the header fields, held while the next parses
      logic [7:0] out_dsap;
      logic [7:0] out_ssap;
      logic [15:0] out_ctrl;
      logic out_ctrl_wide;
      logic [23:0] out_oui;
   } lftc_st_s;

   lftc_st_s st_reg;
   lftc_st_s st_next;

   lftc_len_if lk ();

   lftc_len_count u_len
   (
      .clk(clk),
      .rst(rst),
      .lk(lk)
   );

   assign lk.byte_stb = in_valid;
   assign lk.first = in_first;
   assign lk.ring = in_ring;

   // one byte into the reflected crc32 register
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                            input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ LFTC_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_byte

   // byte position, llc base and offset into the llc header
   logic [12:0] idx;
   logic [12:0] llc_base;
   logic [12:0] off;
   logic in_llc;
   logic len_framed;
   logic snap;
   logic [12:0] need;
   logic [12:0] tl13;

   always_comb
   begin
      idx = in_first ? 13'h0000 : lk.count;
      llc_base = (in_first ? in_ring : st_reg.ring) ? LFTC_RING_LLC
                                                    : LFTC_ETH_LLC;
      off = idx - llc_base;
      in_llc = (idx >= llc_base) && (off < LFTC_OFF_END);
      len_framed = (st_reg.tl <= LFTC_TL_MAX);
      snap = (st_reg.dsap == LFTC_SAP_SNAP)
             && (st_reg.ssap == LFTC_SAP_SNAP);
      tl13 = st_reg.tl[12:0];
      need = llc_base + LFTC_OFF_CTL + LFTC_FCS_LEN
             + 13'h0001;
   end

   // field capture while bytes arrive, verdict once the frame is done
   always_comb
   begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      if (in_valid && in_first)
      begin
         // a first byte restarts parsing, even mid-frame; the last
         // verdict stays on the outputs until the next one replaces it
         st_next.tl = 16'h0000;
         st_next.dsap = 8'h00;
         st_next.ssap = 8'h00;
         st_next.ctrl = 16'h0000;
         st_next.ctrl_wide = 1'b0;
         st_next.oui = 24'h000000;
         st_next.ext = 16'h0000;
         st_next.ring = in_ring;
         st_next.crc = crc_byte(LFTC_CRC_INIT, in_data);
         st_next.state = in_last ? ST_DONE : ST_FRAME;
      end
      else if (in_valid && st_reg.state == ST_FRAME)
      begin
         st_next.crc = crc_byte(st_reg.crc, in_data);
         // fields are read left to right, earlier ones steer later ones
         if (!st_reg.ring && idx == LFTC_ETH_TL_HI)
         begin
            st_next.tl[15:8] = in_data;
         end
         if (!st_reg.ring && idx == LFTC_ETH_TL_HI + 13'h0001)
         begin
            st_next.tl[7:0] = in_data;
         end
         // llc only follows when the field was a length, or on the ring
         if (in_llc && (st_reg.ring || len_framed))
         begin
            unique case (off)
               LFTC_OFF_DSAP: st_next.dsap = in_data;
               LFTC_OFF_SSAP: st_next.ssap = in_data;
               LFTC_OFF_CTL:
               begin
                  st_next.ctrl = {8'h00, in_data};
                  // info and supervisory formats take a second byte
                  st_next.ctrl_wide = !snap
                     && (in_data[1:0] != LFTC_CTL_UNNUM);
               end
               default:
               begin
                  if (st_reg.ctrl_wide && off == LFTC_OFF_CTL2)
                  begin
                     st_next.ctrl = {st_reg.ctrl[7:0], in_data};
                  end
                  if (snap && off < LFTC_OFF_EXT)
                  begin
                     st_next.oui = {st_reg.oui[15:0], in_data};
                  end
                  if (snap && off >= LFTC_OFF_EXT)
                  begin
                     st_next.ext = {st_reg.ext[7:0], in_data};
                  end
               end
            endcase
         end
         if (in_last)
         begin
            st_next.state = ST_DONE;
         end
      end
      else if (st_reg.state == ST_DONE)
      begin
         st_next.state = ST_IDLE;
         st_next.valid = 1'b1;
         st_next.pad_err = 1'b0;
         st_next.out_dsap = st_reg.dsap;
         st_next.out_ssap = st_reg.ssap;
         st_next.out_ctrl = st_reg.ctrl;
         st_next.out_ctrl_wide = st_reg.ctrl_wide;
         st_next.out_oui = st_reg.oui;
         st_next.crc_err = (st_reg.crc != LFTC_CRC_RESID);
         st_next.len_err = lk.too_long || lk.too_short;
         st_next.hdr_err = (lk.count < need);
         if (st_reg.ring)
         begin
            // no raw or type variant exists on the ring
            if (snap)
            begin
               st_next.cls = (st_reg.oui == LFTC_OUI_ENCAP)
                  ? LFTC_CL_RING_SNAP_ENCAP_TYPE
                  : LFTC_CL_RING_FRAMING_WITH_SNAP;
               st_next.proto = st_reg.ext;
            end
            else
            begin
               st_next.cls = LFTC_CL_RING_FRAMING_WITH_LLC;
               st_next.proto = {8'h00, st_reg.dsap};
            end
         end
         else if (!len_framed)
         begin
            st_next.cls = LFTC_CL_TYPE_FIELD_FRAMING;
            st_next.proto = st_reg.tl;
            st_next.hdr_err = (lk.count < LFTC_ETH_LLC + LFTC_FCS_LEN);
         end
         else
         begin
            // padded frames are exactly minimum size, others fit length
            st_next.pad_err = (st_reg.tl < LFTC_PAD_MIN)
               ? (lk.count != LFTC_ETH_MIN)
               : (lk.count < tl13 + LFTC_ETH_OVH);
            if ({st_reg.dsap, st_reg.ssap} == LFTC_RAW_MARK)
            begin
               st_next.cls = LFTC_CL_RAW_LENGTH_FRAMING;
               st_next.proto = LFTC_RAW_MARK;
            end
            else if (snap)
            begin
               st_next.cls = (st_reg.oui == LFTC_OUI_ENCAP)
                  ? LFTC_CL_LENGTH_SNAP_ENCAP_TYPE
                  : LFTC_CL_LENGTH_FRAMING_WITH_SNAP;
               st_next.proto = st_reg.ext;
            end
            else
            begin
               st_next.cls = LFTC_CL_LENGTH_FRAMING_WITH_LLC;
               st_next.proto = {8'h00, st_reg.dsap};
            end
         end
         // snap must use type 1 service with control 3
         if (snap && st_next.cls != LFTC_CL_RAW_LENGTH_FRAMING
             && (st_reg.ctrl[7:0] != LFTC_SNAP_CTL
                 || lk.count < need + LFTC_OFF_END - LFTC_OFF_CTL
                    - 13'h0001))
         begin
            st_next.hdr_err = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // verdict fields hold from one verdict until the next; res_valid is a one-cycle pulse
   assign res_valid = st_reg.valid;
   assign res_class = st_reg.cls;
   assign res_proto = st_reg.proto;
   assign res_dsap = st_reg.out_dsap;
   assign res_ssap = st_reg.out_ssap;
   assign res_ctrl = st_reg.out_ctrl;
   assign res_ctrl_wide = st_reg.out_ctrl_wide;
   assign res_oui = st_reg.out_oui;
   assign res_len_err = st_reg.len_err;
   assign res_pad_err = st_reg.pad_err;
   assign res_crc_err = st_reg.crc_err;
   assign res_hdr_err = st_reg.hdr_err;
   // the switch drops anything flagged rather than forwarding it
   assign res_discard = st_reg.len_err | st_reg.pad_err
                        | st_reg.crc_err | st_reg.hdr_err;
endmodule : lftc_classifier
`default_nettype wire

// [bench/lftc_classifier_assertions.sv]
// Purpose: concurrent checks on the classifier verdict ports
// Assumes: frames of 14 bytes or more, an idle cycle between frames
// Notes: helper logic counts bytes so limits are judged on its own count
`timescale 1ns/1ps
`default_nettype none
module lftc_classifier_assertions
   import lftc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_first,
   input wire logic in_last,
   input wire logic in_ring,
   input wire logic res_valid,
   input wire logic [3:0] res_class,
   input wire logic [15:0] res_proto,
   input wire logic [23:0] res_oui,
   input wire logic res_len_err,
   input wire logic res_pad_err,
   input wire logic res_crc_err,
   input wire logic res_hdr_err,
   input wire logic res_discard
);
   logic [12:0] idx_reg;
   logic [12:0] n_reg;
   logic [15:0] tl_reg;
   logic ring_reg;
   // byte index, frame length, type/length field and medium per frame
   always_ff @(posedge clk)
   begin
      if (rst)
         idx_reg <= 13'h0000;
      else if (in_valid && (in_first || idx_reg != 13'h0000))
      begin
         idx_reg <= in_last ? 13'h0000 :
            (in_first ? 13'h0001 : idx_reg + 13'h0001);
         n_reg <= (in_first ? 13'h0000 : idx_reg) + 13'h0001;
         if (in_first) ring_reg <= in_ring;
         if (idx_reg == 13'h000C) tl_reg[15:8] <= in_data;
         if (idx_reg == 13'h000D) tl_reg[7:0] <= in_data;
      end
   end
   AST_ANSWER: assert property (@(posedge clk) disable iff (rst)
      in_valid && in_last && idx_reg != 13'h0000 ##1 !(in_valid && in_first)
      |=> res_valid) else $error("no verdict after last byte");
   AST_NO_STRAY: assert property (@(posedge clk) disable iff (rst)
      res_valid |-> $past(in_valid && in_last, 2))
      else $error("verdict without a last byte");
   AST_DISCARD: assert property (@(posedge clk) disable iff (rst)
      res_valid |-> res_discard == (res_len_err || res_pad_err ||
      res_crc_err || res_hdr_err)) else $error("discard flag wrong");
   AST_HOLD: assert property (@(posedge clk) disable iff (rst)
      !res_valid && !$past(rst) |-> $stable({res_class, res_proto, res_oui,
      res_discard})) else $error("verdict changed between frames");
   AST_SPLIT: assert property (@(posedge clk) disable iff (rst)
      res_valid && !ring_reg && !res_hdr_err |-> (tl_reg > LFTC_TL_MAX) ==
      (res_class == LFTC_CL_TYPE_FIELD_FRAMING))
      else $error("type and length split wrong");
   AST_RAW: assert property (@(posedge clk) disable iff (rst)
      res_valid && res_class == LFTC_CL_RAW_LENGTH_FRAMING
      |-> res_proto == 16'hFFFF) else $error("raw frame proto wrong");
   AST_ENCAP: assert property (@(posedge clk) disable iff (rst)
      res_valid && res_class inside {LFTC_CL_LENGTH_FRAMING_WITH_SNAP,
      LFTC_CL_RING_FRAMING_WITH_SNAP} |-> res_oui != 24'h000000)
      else $error("zero oui not taken as encapsulation");
   AST_MEDIUM: assert property (@(posedge clk) disable iff (rst)
      res_valid && res_class != LFTC_CL_NONE |-> ring_reg == (res_class inside
      {LFTC_CL_RING_FRAMING_WITH_LLC, LFTC_CL_RING_FRAMING_WITH_SNAP,
      LFTC_CL_RING_SNAP_ENCAP_TYPE})) else $error("medium wrong");
   AST_LEN: assert property (@(posedge clk) disable iff (rst)
      res_valid |-> res_len_err == (ring_reg ? (n_reg < LFTC_RING_MIN ||
      n_reg > LFTC_RING_MAX) : (n_reg < LFTC_ETH_MIN || n_reg > LFTC_ETH_MAX)))
      else $error("length flag wrong");
endmodule : lftc_classifier_assertions
bind lftc_classifier lftc_classifier_assertions chk_u (.clk, .rst, .in_valid,
   .in_data, .in_first, .in_last, .in_ring, .res_valid, .res_class, .res_proto,
   .res_oui, .res_len_err, .res_pad_err, .res_crc_err, .res_hdr_err,
   .res_discard);
`default_nettype wire

// [bench/lftc_mac_model.sv]
// Purpose: receive path of the mac feeding frame bytes to the classifier
// Assumes: bytes change at the falling edge, taken at the rising edge
// Notes: a released data line toggles so no stale byte can be read
`timescale 1ns/1ps
`default_nettype none
module lftc_mac_model (
   input wire logic clk,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic in_first,
   output logic in_last,
   output logic in_ring
);
   // idle at time zero
   initial
   begin
      in_valid = 1'b0;
      in_data = 8'h00;
      in_first = 1'b0;
      in_last = 1'b0;
      in_ring = 1'b0;
   end
   // bytes leave start to end; a cut frame never flags its last byte
   task automatic send(input logic [7:0] q[$], input logic ring, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         in_valid = 1'b1;
         in_data = q[i];
         in_first = (i == 0);
         in_last = (i == q.size() - 1);
         in_ring = ring;
      end
      @(negedge clk);
      in_valid = 1'b0;
      in_first = 1'b0;
      in_last = 1'b0;
      in_data = ~in_data;
   endtask : send
endmodule : lftc_mac_model
`default_nettype wire

// [bench/lan_frame_type_classifier_tb.sv]
// Purpose: self-checking bench for the frame type classifier
// Assumes: the mac model offers bytes at the falling edge
// Notes: fcs is computed here so only chosen frames carry errors
`timescale 1ns/1ps
`default_nettype none
module lan_frame_type_classifier_tb
   import lftc_pkg::*;
;
   logic clk, rst, in_valid, in_first, in_last, in_ring;
   logic [7:0] in_data;
   logic res_valid, res_ctrl_wide;
   lftc_class_e res_class;
   logic [15:0] res_proto, res_ctrl;
   logic [7:0] res_dsap, res_ssap;
   logic [23:0] res_oui;
   logic res_len_err, res_pad_err, res_crc_err, res_hdr_err, res_discard;
   logic [7:0] fr[$];
   int failures = 0;
   int n_tests = 0;
   localparam lftc_class_e c_typ = LFTC_CL_TYPE_FIELD_FRAMING;
   localparam lftc_class_e c_llc = LFTC_CL_LENGTH_FRAMING_WITH_LLC;
   lftc_classifier dut_u (.clk, .rst, .in_valid, .in_data, .in_first,
      .in_last, .in_ring, .res_valid, .res_class, .res_proto, .res_dsap,
      .res_ssap, .res_ctrl, .res_ctrl_wide, .res_oui, .res_len_err,
      .res_pad_err, .res_crc_err, .res_hdr_err, .res_discard);
   lftc_mac_model mac_u (.clk, .in_valid, .in_data, .in_first, .in_last,
      .in_ring);
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // addresses, then a type/length field on ethernet only
   task automatic hdr(input logic ring, input logic [15:0] tl);
      fr = {};
      if (ring) fr = {8'h50};
      for (int i = 0; i < 12; i++) fr.push_back(8'h10 + 8'(i));
      if (!ring) fr = {fr, tl[15:8], tl[7:0]};
   endtask : hdr
   // pad to n-4, add fcs (bad spoils it), send and judge the verdict
   task automatic run(input logic ring, input int n, input logic bad,
      input lftc_class_e cl, input logic [15:0] pr, input logic [3:0] err);
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      while (fr.size() < n - 4) fr.push_back(8'h00);
      foreach (fr[i])
      begin
         c = c ^ {24'h000000, fr[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ LFTC_CRC_POLY : c >> 1;
      end
      c = ~c ^ {31'h00000000, bad};
      fr = {fr, c[7:0], c[15:8], c[23:16], c[31:24]};
      mac_u.send(fr, ring, n);
      @(posedge clk);
      #1;
      chk("valid", res_valid, 1'b1);
      if (cl != LFTC_CL_NONE) chk("class", res_class, cl);
      if (cl != LFTC_CL_NONE) chk("proto", res_proto, pr);
      chk("errors", {res_len_err, res_pad_err, res_crc_err, res_hdr_err},
         err);
      chk("discard", res_discard, |err);
   endtask : run
   task automatic t_split();
      hdr(1'b0, 16'h05DD);
      run(1'b0, 64, 1'b0, c_typ, 16'h05DD, 4'h0);
      hdr(1'b0, 16'h05DC);
      fr = {fr, 8'hE0, 8'hE0, 8'h03};
      run(1'b0, 1518, 1'b0, c_llc, 16'h00E0, 4'h0);
      chk("ssap", res_ssap, 8'hE0);
      chk("ctrl", {res_ctrl_wide, res_ctrl}, 17'h00003);
   endtask : t_split
   task automatic t_raw_ctl();
      hdr(1'b0, 16'h002E);
      fr = {fr, 8'hFF, 8'hFF};
      run(1'b0, 64, 1'b0, LFTC_CL_RAW_LENGTH_FRAMING, 16'hFFFF, 4'h0);
      hdr(1'b0, 16'h0010);
      fr = {fr, 8'hF0, 8'hF0, 8'h04, 8'h02};
      run(1'b0, 64, 1'b0, c_llc, 16'h00F0, 4'h0);
      chk("ctrl2", {res_ctrl_wide, res_ctrl}, 17'h10402);
      chk("dsap", res_dsap, 8'hF0);
   endtask : t_raw_ctl
   task automatic t_snap();
      lftc_class_e cls[4] = '{LFTC_CL_LENGTH_FRAMING_WITH_SNAP,
         LFTC_CL_LENGTH_SNAP_ENCAP_TYPE, LFTC_CL_RING_FRAMING_WITH_SNAP,
         LFTC_CL_RING_SNAP_ENCAP_TYPE};
      logic [23:0] o;
      for (int k = 0; k < 4; k++)
      begin
         hdr(k[1], 16'h0010);
         o = k[0] ? 24'h000000 : 24'h080007;
         fr = {fr, 8'hAA, 8'hAA, 8'h03, o[23:16], o[15:8], o[7:0], 8'h81,
            8'h37};
         run(k[1], 64, 1'b0, cls[k], 16'h8137, 4'h0);
         chk("oui", res_oui, o);
      end
      hdr(1'b0, 16'h0010);
      fr = {fr, 8'hAA, 8'hAA, 8'h13};
      run(1'b0, 64, 1'b0, LFTC_CL_NONE, 16'h0000, 4'h1);
   endtask : t_snap
   task automatic t_len();
      int n[6] = '{63, 64, 1518, 1519, 4500, 4501};
      logic [5:0] e = 6'h29;
      for (int i = 0; i < 6; i++)
      begin
         hdr(i > 3, 16'h0800);
         if (i > 3) fr = {fr, 8'hE0, 8'hE0, 8'h03};
         run(i > 3, n[i], 1'b0, i > 3 ? LFTC_CL_RING_FRAMING_WITH_LLC : c_typ,
            i > 3 ? 16'h00E0 : 16'h0800, {e[i], 3'h0});
      end
   endtask : t_len
   task automatic t_pad_crc();
      hdr(1'b0, 16'h0010);
      fr = {fr, 8'hE0, 8'hE0, 8'h03};
      run(1'b0, 68, 1'b0, c_llc, 16'h00E0, 4'h4);
      hdr(1'b0, 16'h0040);
      fr = {fr, 8'hE0, 8'hE0, 8'h03};
      run(1'b0, 64, 1'b0, c_llc, 16'h00E0, 4'h4);
      hdr(1'b0, 16'h0800);
      run(1'b0, 64, 1'b1, c_typ, 16'h0800, 4'h2);
   endtask : t_pad_crc
   // a frame cut short and restarted gives one verdict only
   task automatic t_restart();
      hdr(1'b0, 16'h0800);
      // queue longer than what is sent, so no byte carries the last flag
      while (fr.size() < 64) fr.push_back(8'h00);
      mac_u.send(fr, 1'b0, 30);
      @(posedge clk);
      #1;
      chk("cut valid", res_valid, 1'b0);
      hdr(1'b0, 16'h0801);
      run(1'b0, 64, 1'b0, c_typ, 16'h0801, 4'h0);
   endtask : t_restart
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // reset for three cycles, then every scenario in turn
   initial
   begin
      rst = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("rst class", {res_valid, res_class}, 5'h00);
      t_split();
      t_raw_ctl();
      t_snap();
      t_len();
      t_pad_crc();
      t_restart();
      final_report();
   end
endmodule : lan_frame_type_classifier_tb
`default_nettype wire
